/* rtl/adc_seq_pkg.sv */
// Package: register map, field layout, mode codes and timing for the channel sequencer
package adc_seq_pkg;
   localparam int          ADDR_W          = 7;
   localparam int          DATA_W          = 16;
   localparam int          VEC_W           = 32;
   localparam int          CHAN_W          = 5;
   // Register offsets on the configuration port
   localparam logic [6:0]  OFS_CONFIG_ZERO = 7'h40;
   localparam logic [6:0]  OFS_CONFIG_ONE  = 7'h41;
   localparam logic [6:0]  OFS_SEL_ONCHIP  = 7'h48;
   localparam logic [6:0]  OFS_SEL_AUX     = 7'h49;
   localparam logic [6:0]  OFS_AVG_ONCHIP  = 7'h4A;
   localparam logic [6:0]  OFS_AVG_AUX     = 7'h4B;
   localparam logic [6:0]  OFS_MODE_ONCHIP = 7'h4C;
   localparam logic [6:0]  OFS_MODE_AUX    = 7'h4D;
   localparam logic [6:0]  OFS_SETL_ONCHIP = 7'h4E;
   localparam logic [6:0]  OFS_SETL_AUX    = 7'h4F;
   // Field positions in conversion_config_zero
   localparam int          CH_LSB          = 0;
   localparam int          SETTLE_POS      = 8;
   localparam int          BIPOLAR_POS     = 10;
   // Field position of the scan mode in conversion_config_one
   localparam int          MODE_LSB        = 12;
   // Scan mode codes
   localparam logic [3:0]  MODE_DEFAULT    = 4'h0;
   localparam logic [3:0]  MODE_ONE_PASS   = 4'h1;
   localparam logic [3:0]  MODE_CONTINUOUS = 4'h2;
   localparam logic [3:0]  MODE_SINGLE     = 4'h3;
   localparam logic [3:0]  MODE_SIMULT     = 4'h4;
   localparam logic [3:0]  MODE_INDEP      = 4'h8;
   // Reset values
   localparam logic [15:0] RST_REG         = 16'h0000;
   // Fixed default-mode scan: calibration plus on-chip sensors
   localparam logic [31:0] DEFAULT_SCAN    = 32'h0000_47E1;
   // Time of one conversion, and its cycle count at the system clock
   localparam int          CLK_MHZ         = 125;
   localparam int          CONV_NS         = 1000;
   localparam int          CONV_CYC        = (CONV_NS * CLK_MHZ + 999) / 1000;
   localparam int          SIM_PAIRS       = 8;
endpackage : adc_seq_pkg

/* rtl/scan_pick.sv */
// Picker: next enabled scan position at or after a start index
`timescale 1ns/1ps
module scan_pick
   import adc_seq_pkg::*;
(
   input  wire logic [VEC_W-1:0]  vec_i,   // Enable vector
   input  wire logic [CHAN_W-1:0] from_i,  // First position to consider
   output logic                   found_o, // Some position found
   output logic [CHAN_W-1:0]      pos_o    // Found position
);
   ////////////////////////////////////////////////////////////////
   // Lowest set bit at or above from_i; no wrap, caller restarts
   always_comb
   begin
      found_o = 1'b0;
      pos_o   = '0;
      for (int i = VEC_W - 1; i >= 0; i--)
      begin
         if (vec_i[i] && (i >= int'(from_i)))
         begin
            found_o = 1'b1;
            pos_o   = CHAN_W'(i);
         end
      end
   end
endmodule : scan_pick

/* rtl/adc_channel_sequencer.sv */
// Channel sequencer: register file, mode decode and scan stepping
//
// Behaviour
// - Mode pattern 0011 selects single channel mode
// - Sequencer applies per-channel settings, stores results
// - Eight 16-bit registers form four 32-bit vectors
// - Pairs: select, average, input mode, settling
// - Select bit one includes, zero excludes channel
// - Fixed order, onchip bit0 to aux bit15
// - Onchip bits map to channels 8,13-15,0-6
// - Aux bit n is channel 16 plus n
// - Simultaneous and independent modes step differently; here independent mode steps like continuous
// - Every mode runs continuous or event-driven
// - Default mode scans on-chip sensors without setup
// - Simultaneous mode converts two inputs together
// - All-zero mode bits select default mode
// - One pass then fall back to single channel
// - Mode write restarts logic, keeps status contents
`timescale 1ns/1ps
module adc_channel_sequencer
   import adc_seq_pkg::*;
(
   input  wire logic              clk_sys_i,    // System clock, 125 MHz
   input  wire logic              rstn_i,       // Asynchronous reset, active low
   input  wire logic              cfg_en_i,     // Configuration port strobe
   input  wire logic              cfg_we_i,     // Write when high
   input  wire logic [ADDR_W-1:0] cfg_addr_i,   // Register offset
   input  wire logic [DATA_W-1:0] cfg_di_i,     // Write data
   output logic [DATA_W-1:0]      cfg_do_o,     // Read data
   output logic                   cfg_rdy_o,    // Access done pulse
   input  wire logic              event_mode_i, // Event-driven sampling when high
   input  wire logic              convst_i,     // Conversion start pin, async
   output logic                   conv_go_o,    // Start conversion pulse
   output logic [CHAN_W-1:0]      chan_a_o,     // Converter A channel
   output logic [CHAN_W-1:0]      chan_b_o,     // Converter B channel
   output logic                   dual_o,       // Both converters in lock step
   output logic                   avg_o,        // Average this channel
   output logic                   bipolar_o,    // Bipolar input
   output logic                   settle_o,     // Extended settling
   output logic                   store_o,      // Store result pulse
   output logic                   seq_reset_o,  // Converter logic restart pulse
   output logic                   eos_o         // End of sequence pulse
);
   typedef enum logic [1:0] {ST_IDLE, ST_PICK, ST_CONV} seq_state_e;

   // Configuration registers; the four pairs held as 32-bit vectors
   logic [DATA_W-1:0] cfg0_ff;                  // conversion_config_zero
   logic [DATA_W-1:0] cfg1_ff;                  // conversion_config_one
   logic [VEC_W-1:0]  sel_ff;                   // scan_select pair
   logic [VEC_W-1:0]  avgv_ff;                  // scan_average pair
   logic [VEC_W-1:0]  modev_ff;                 // scan_input_mode pair
   logic [VEC_W-1:0]  setlv_ff;                 // scan_settle pair
   logic              restart_ff;               // Mode write seen
   logic              one_pass_done_ff;         // Single pass finished
   seq_state_e        state_ff;                 // Sequencer state
   logic [CHAN_W-1:0] pos_ff;                   // Current bit position
   logic [7:0]        timer_ff;                 // Conversion timer
   logic [2:0]        cv_sync_ff;               // Start pin synchroniser
   logic              cv_level_ff;              // Filtered start level
   logic              fresh_ff;                 // Next pick starts at position 0

   logic [3:0]        mode;                     // Requested mode
   logic [3:0]        eff_mode;                 // Mode after one-pass fallback
   logic [VEC_W-1:0]  scan_vec;                 // Vector being scanned
   logic              pick_found;               // Picker result valid
   logic [CHAN_W-1:0] pick_pos;                 // Picker result
   logic [CHAN_W-1:0] pick_from;                // Picker start
   logic              cfg_wr;                   // Write strobe
   logic              trig;                     // Start of a conversion allowed
   logic              cv_rise;                  // Start pin rising edge
   logic              pass_end;                 // No further position in this pass

   ////////////////////////////////////////////////////////////////
   // Bit position to converter channel
   function automatic logic [CHAN_W-1:0] pos_to_chan(input logic [CHAN_W-1:0] p);
      logic [CHAN_W-1:0] c;
      c = p;                                    // Aux half maps 1:1
      if (p < 5'd16)
      begin
         if (p == 5'd0)
            c = 5'd8;                           // Calibration
         else if (p <= 5'd7)
            c = p + 5'd8;                       // Bits 5..7 give 13..15
         else
            c = p - 5'd8;                       // Bits 8..14 give 0..6
      end
      return c;
   endfunction : pos_to_chan

   assign cfg_wr   = cfg_en_i && cfg_we_i;
   assign mode     = cfg1_ff[MODE_LSB +: 4];
   // Finished single pass reads as single channel
   assign eff_mode = one_pass_done_ff ? MODE_SINGLE : mode;
   // Default mode ignores the select pair
   assign scan_vec = (eff_mode == MODE_DEFAULT) ? DEFAULT_SCAN :
                     (eff_mode == MODE_SIMULT)  ? {sel_ff[31:24], 24'h000000} :
                     sel_ff;
   assign pick_from = fresh_ff ? 5'd0 : pos_ff + 5'd1;
   // Position counter would wrap past aux bit 15 back to bit 0, so stop there
   assign pass_end  = !pick_found || (!fresh_ff && (pos_ff == 5'(VEC_W - 1)));
   assign cv_rise  = (cv_sync_ff[2] == cv_sync_ff[1]) && cv_sync_ff[1] && !cv_level_ff;
   // Either sampling style
   assign trig     = event_mode_i ? cv_rise : 1'b1;

   scan_pick u_pick
   (
      .vec_i   (scan_vec),
      .from_i  (pick_from),
      .found_o (pick_found),
      .pos_o   (pick_pos)
   );

   ////////////////////////////////////////////////////////////////
   // Register writes; pairs land in low and high halves
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cfg0_ff  <= RST_REG;
         cfg1_ff  <= RST_REG;
         sel_ff   <= {RST_REG, RST_REG};
         avgv_ff  <= {RST_REG, RST_REG};
         modev_ff <= {RST_REG, RST_REG};
         setlv_ff <= {RST_REG, RST_REG};
      end
      else if (cfg_wr)
      begin
         unique case (cfg_addr_i)
            OFS_CONFIG_ZERO: cfg0_ff         <= cfg_di_i;
            OFS_CONFIG_ONE:  cfg1_ff         <= cfg_di_i;
            OFS_SEL_ONCHIP:  sel_ff[15:0]    <= cfg_di_i;
            OFS_SEL_AUX:     sel_ff[31:16]   <= cfg_di_i;
            OFS_AVG_ONCHIP:  avgv_ff[15:0]   <= cfg_di_i;
            OFS_AVG_AUX:     avgv_ff[31:16]  <= cfg_di_i;
            OFS_MODE_ONCHIP: modev_ff[15:0]  <= cfg_di_i;
            OFS_MODE_AUX:    modev_ff[31:16] <= cfg_di_i;
            OFS_SETL_ONCHIP: setlv_ff[15:0]  <= cfg_di_i;
            OFS_SETL_AUX:    setlv_ff[31:16] <= cfg_di_i;
            default:         ;                  // Unmapped writes dropped
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read port and ready pulse; unmapped reads return zero
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cfg_do_o  <= RST_REG;
         cfg_rdy_o <= 1'b0;
      end
      else
      begin
         cfg_rdy_o <= cfg_en_i;
         if (cfg_en_i && !cfg_we_i)
         begin
            unique case (cfg_addr_i)
               OFS_CONFIG_ZERO: cfg_do_o <= cfg0_ff;
               OFS_CONFIG_ONE:  cfg_do_o <= cfg1_ff;
               OFS_SEL_ONCHIP:  cfg_do_o <= sel_ff[15:0];
               OFS_SEL_AUX:     cfg_do_o <= sel_ff[31:16];
               OFS_AVG_ONCHIP:  cfg_do_o <= avgv_ff[15:0];
               OFS_AVG_AUX:     cfg_do_o <= avgv_ff[31:16];
               OFS_MODE_ONCHIP: cfg_do_o <= modev_ff[15:0];
               OFS_MODE_AUX:    cfg_do_o <= modev_ff[31:16];
               OFS_SETL_ONCHIP: cfg_do_o <= setlv_ff[15:0];
               OFS_SETL_AUX:    cfg_do_o <= setlv_ff[31:16];
               default:         cfg_do_o <= RST_REG;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Start pin: three flops, edge counted when the last two agree
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cv_sync_ff  <= 3'b000;
         cv_level_ff <= 1'b0;
      end
      else
      begin
         cv_sync_ff <= {cv_sync_ff[1:0], convst_i};
         if (cv_sync_ff[2] == cv_sync_ff[1])
            cv_level_ff <= cv_sync_ff[1];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Mode write restarts stepping; status contents live elsewhere
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         restart_ff  <= 1'b0;
         seq_reset_o <= 1'b0;
      end
      else
      begin
         restart_ff  <= cfg_wr && (cfg_addr_i == OFS_CONFIG_ONE);
         seq_reset_o <= cfg_wr && (cfg_addr_i == OFS_CONFIG_ONE);
      end
   end

   ////////////////////////////////////////////////////////////////
   // Sequencer stepping and per-channel setting outputs
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_ff         <= ST_IDLE;
         pos_ff           <= '0;
         timer_ff         <= '0;
         fresh_ff         <= 1'b1;
         one_pass_done_ff <= 1'b0;
         conv_go_o        <= 1'b0;
         store_o          <= 1'b0;
         eos_o            <= 1'b0;
         chan_a_o         <= '0;
         chan_b_o         <= '0;
         dual_o           <= 1'b0;
         avg_o            <= 1'b0;
         bipolar_o        <= 1'b0;
         settle_o         <= 1'b0;
      end
      else if (restart_ff)
      begin
         // Averaging restarts too, since the converter is reset
         state_ff         <= ST_IDLE;
         pos_ff           <= '0;
         fresh_ff         <= 1'b1;               // Scan restarts at bit 0
         one_pass_done_ff <= 1'b0;
         conv_go_o        <= 1'b0;
         store_o          <= 1'b0;
         eos_o            <= 1'b0;
      end
      else
      begin
         conv_go_o <= 1'b0;
         store_o   <= 1'b0;
         eos_o     <= 1'b0;
         unique case (state_ff)
            ST_IDLE:
            begin
               if (trig)
                  state_ff <= ST_PICK;
            end
            ST_PICK:
            begin
               if (eff_mode == MODE_SINGLE)
               begin
                  // Channel and settings straight from config zero
                  chan_a_o  <= cfg0_ff[CH_LSB +: CHAN_W];
                  dual_o    <= 1'b0;
                  avg_o     <= 1'b0;
                  bipolar_o <= cfg0_ff[BIPOLAR_POS];
                  settle_o  <= cfg0_ff[SETTLE_POS];
                  conv_go_o <= 1'b1;
                  timer_ff  <= 8'(CONV_CYC);
                  state_ff  <= ST_CONV;
               end
               else if (!pass_end)
               begin
                  // Jump to next set bit, skipping zeros
                  pos_ff    <= pick_pos;
                  fresh_ff  <= 1'b0;
                  chan_a_o  <= pos_to_chan(pick_pos);
                  // Simultaneous: pair aux n with aux n+8
                  chan_b_o  <= pos_to_chan(pick_pos) - 5'(SIM_PAIRS);
                  dual_o    <= (eff_mode == MODE_SIMULT);
                  // Per-channel settings
                  avg_o     <= (eff_mode == MODE_DEFAULT) | avgv_ff[pick_pos];
                  bipolar_o <= modev_ff[pick_pos];
                  settle_o  <= setlv_ff[pick_pos];
                  conv_go_o <= 1'b1;
                  timer_ff  <= 8'(CONV_CYC);
                  state_ff  <= ST_CONV;
               end
               else
               begin
                  // End of pass
                  eos_o    <= !fresh_ff;          // Only if something was converted
                  fresh_ff <= 1'b1;
                  pos_ff   <= '0;
                  state_ff <= ST_IDLE;
                  if (eff_mode == MODE_ONE_PASS)
                     one_pass_done_ff <= 1'b1;
               end
            end
            ST_CONV:
            begin
               if (timer_ff > 8'd1)
                  timer_ff <= timer_ff - 8'd1;
               else
               begin
                  store_o <= 1'b1;               // Result to status
                  // Independent mode: converter B stays on its own duties
                  state_ff <= (eff_mode == MODE_SINGLE) ? ST_IDLE :
                              (event_mode_i ? ST_IDLE : ST_PICK);
               end
            end
         endcase
      end
   end
endmodule : adc_channel_sequencer

/* testbench/adc_seq_sva.sv */
// Checker: bus answer, mode restart, conversion timing and channel settings
`timescale 1ns/1ps
module adc_seq_sva
   import adc_seq_pkg::*;
(
   input wire logic              clk_sys_i,
   input wire logic              rstn_i,
   input wire logic              cfg_en_i,
   input wire logic              cfg_we_i,
   input wire logic [ADDR_W-1:0] cfg_addr_i,
   input wire logic [DATA_W-1:0] cfg_di_i,
   input wire logic              cfg_rdy_o,
   input wire logic              conv_go_o,
   input wire logic [CHAN_W-1:0] chan_a_o,
   input wire logic [CHAN_W-1:0] chan_b_o,
   input wire logic              dual_o,
   input wire logic              avg_o,
   input wire logic              bipolar_o,
   input wire logic              settle_o,
   input wire logic              store_o,
   input wire logic              seq_reset_o,
   input wire logic              eos_o
);
   ////////////////////////////////////////////////////////////////////////
   logic [15:0] cfg0_ff;                         // Single channel settings
   logic [3:0]  mode_ff;                         // Scan mode field
   logic [31:0] sel_ff, avg_ff, bip_ff, setl_ff; // Per-channel vectors
   logic        done_ff;                         // One pass over
   logic [7:0]  cnt_ff;                          // Cycles since a start
   wire         wr_en   = cfg_en_i && cfg_we_i;
   wire         mode_wr = wr_en && cfg_addr_i == OFS_CONFIG_ONE;
   // On-chip half of the vector swaps bit 3 of the channel
   wire [4:0]   bpos    = chan_a_o[4] ? chan_a_o : chan_a_o ^ 5'h08;
   // A start racing a mode write still belongs to the old mode
   wire         go      = conv_go_o && !seq_reset_o;
   wire         seqm    = !done_ff &&
                          mode_ff inside {MODE_ONE_PASS, MODE_CONTINUOUS, MODE_INDEP};

   // Register shadow, updated at the taking edge
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
         {cfg0_ff, sel_ff, avg_ff, bip_ff, setl_ff} <= '0;
      else if (wr_en)
      begin
         case (cfg_addr_i)
            OFS_CONFIG_ZERO: cfg0_ff        <= cfg_di_i;
            OFS_SEL_ONCHIP:  sel_ff[15:0]   <= cfg_di_i;
            OFS_SEL_AUX:     sel_ff[31:16]  <= cfg_di_i;
            OFS_AVG_ONCHIP:  avg_ff[15:0]   <= cfg_di_i;
            OFS_AVG_AUX:     avg_ff[31:16]  <= cfg_di_i;
            OFS_MODE_ONCHIP: bip_ff[15:0]   <= cfg_di_i;
            OFS_MODE_AUX:    bip_ff[31:16]  <= cfg_di_i;
            OFS_SETL_ONCHIP: setl_ff[15:0]  <= cfg_di_i;
            OFS_SETL_AUX:    setl_ff[31:16] <= cfg_di_i;
            default: ;
         endcase
      end
   end

   // Mode shadow; a finished single pass falls back to single channel
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
         {mode_ff, done_ff} <= '0;
      else if (mode_wr)
         {mode_ff, done_ff} <= {cfg_di_i[MODE_LSB+:4], 1'h0};
      else if (eos_o && mode_ff == MODE_ONE_PASS)
         done_ff <= 1'h1;
   end

   // Conversion age; saturates so idle time never wraps
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
         cnt_ff <= 8'hFF;
      else if (seq_reset_o)
         cnt_ff <= 8'hFF;
      else if (conv_go_o)
         cnt_ff <= 8'h00;
      else if (cnt_ff != 8'hFF)
         cnt_ff <= cnt_ff + 8'h01;
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);

   property p_rdy; cfg_en_i |=> cfg_rdy_o; endproperty
   a_rdy: assert property (p_rdy) else $error("access not answered");
   property p_rdy_idle; !cfg_en_i |=> !cfg_rdy_o; endproperty
   a_rdy_idle: assert property (p_rdy_idle) else $error("stray answer");
   property p_mode_rst; mode_wr |=> seq_reset_o; endproperty
   a_mode_rst: assert property (p_mode_rst) else $error("no restart");
   property p_rst_cause; seq_reset_o |-> $past(mode_wr); endproperty
   a_rst_cause: assert property (p_rst_cause) else $error("stray restart");
   property p_single;
      go && (mode_ff == MODE_SINGLE || done_ff) |-> chan_a_o == cfg0_ff[CH_LSB+:CHAN_W]
         && settle_o == cfg0_ff[SETTLE_POS] && bipolar_o == cfg0_ff[BIPOLAR_POS];
   endproperty
   a_single: assert property (p_single) else $error("single setting");
   property p_default; go && mode_ff == MODE_DEFAULT |-> DEFAULT_SCAN[bpos] && avg_o; endproperty
   a_default: assert property (p_default) else $error("default scan");
   property p_vec;
      go && seqm |-> sel_ff[bpos] && avg_o == avg_ff[bpos] && bipolar_o == bip_ff[bpos]
         && settle_o == setl_ff[bpos] && !dual_o;
   endproperty
   a_vec: assert property (p_vec) else $error("channel settings");
   property p_dual;
      go && mode_ff == MODE_SIMULT |-> dual_o && chan_a_o[4:3] == 2'h3
         && chan_b_o == chan_a_o - 5'h08;
   endproperty
   a_dual: assert property (p_dual) else $error("pair wrong");
   property p_store; store_o |-> cnt_ff inside {[CONV_CYC-3:CONV_CYC+3]}; endproperty
   a_store: assert property (p_store) else $error("store timing");
   property p_gap; go |-> cnt_ff >= CONV_CYC - 3; endproperty
   a_gap: assert property (p_gap) else $error("start too early");

   c_dual: cover property (conv_go_o && dual_o);
   c_pass: cover property (eos_o && mode_ff == MODE_ONE_PASS);
   c_rst:  cover property (seq_reset_o);
   c_store: cover property (store_o);
endmodule : adc_seq_sva

bind adc_channel_sequencer adc_seq_sva i_sva (.clk_sys_i, .rstn_i, .cfg_en_i, .cfg_we_i,
   .cfg_addr_i, .cfg_di_i, .cfg_rdy_o, .conv_go_o, .chan_a_o, .chan_b_o, .dual_o, .avg_o,
   .bipolar_o, .settle_o, .store_o, .seq_reset_o, .eos_o);

/* testbench/tb.sv */
// Testbench: register port, scan order and mode behaviour of the sequencer
`timescale 1ns/1ps
module tb
   import adc_seq_pkg::*;
;
   ////////////////////////////////////////////////////////////////////////
   logic              clk_sys_i    = 1'h0;
   logic              rstn_i       = 1'h0;
   logic              cfg_en_i     = 1'h0;
   logic              cfg_we_i     = 1'h0;
   logic [ADDR_W-1:0] cfg_addr_i   = 7'h00;
   logic [DATA_W-1:0] cfg_di_i     = 16'h0000;
   logic              event_mode_i = 1'h0;
   logic              convst_i     = 1'h0;
   logic [DATA_W-1:0] cfg_do_o;
   logic [CHAN_W-1:0] chan_a_o, chan_b_o;
   logic              cfg_rdy_o, conv_go_o, dual_o, avg_o, bipolar_o, settle_o;
   logic              store_o, seq_reset_o, eos_o;
   int                miscompares  = 0;    // Mismatches seen
   int                num_checks   = 0;    // Comparisons made
   logic [16:0]       rd_q [$];            // Expected answers: read flag, data
   logic [4:0]        ch_q [$];            // Expected channels, start order
   logic              strict       = 1'h0; // Unexpected starts are errors
   logic [16:0]       exp_rd;              // Oldest expected answer
   logic [15:0]       wd;                  // Scratch
   logic [15:0]       val  [10];           // Values written per register
   logic [6:0]        offs [10] = '{OFS_CONFIG_ZERO, OFS_CONFIG_ONE, OFS_SEL_ONCHIP,
      OFS_SEL_AUX, OFS_AVG_ONCHIP, OFS_AVG_AUX, OFS_MODE_ONCHIP, OFS_MODE_AUX,
      OFS_SETL_ONCHIP, OFS_SETL_AUX};

   always #4 clk_sys_i = ~clk_sys_i; // 125 MHz

   adc_channel_sequencer i_dut (.clk_sys_i, .rstn_i, .cfg_en_i, .cfg_we_i, .cfg_addr_i,
      .cfg_di_i, .cfg_do_o, .cfg_rdy_o, .event_mode_i, .convst_i, .conv_go_o, .chan_a_o,
      .chan_b_o, .dual_o, .avg_o, .bipolar_o, .settle_o, .store_o, .seq_reset_o, .eos_o);

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   // One access; en is a single-cycle strobe, answer due one cycle later
   task automatic acc(input logic we, input logic [6:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      cfg_en_i   <= 1'h1;
      cfg_we_i   <= we;
      cfg_addr_i <= a;
      cfg_di_i   <= d;
      rd_q.push_back({!we, d});
      @(posedge clk_sys_i);
      cfg_en_i   <= 1'h0;
   endtask : acc

   task automatic set_mode(input logic [3:0] m);
      acc(1'h1, OFS_CONFIG_ONE, 16'(m) << MODE_LSB);
   endtask : set_mode

   // Expected start order of a vector: on-chip half swaps bit 3
   task automatic scan(input logic [31:0] v);
      for (int b = 0; b < 32; b++)
         if (v[b])
            ch_q.push_back(b < 16 ? 5'(b ^ 8) : 5'(b));
   endtask : scan

   // Bounded wait until every expected start was seen
   task automatic drain(input int lim, input string nm);
      int n;
      @(negedge clk_sys_i);
      for (n = 0; n < lim && ch_q.size() != 0; n++)
         @(posedge clk_sys_i);
      if (ch_q.size() != 0 || rd_q.size() != 0)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t %s: activity missing", $time, nm);
         test_done();
      end
      else
         $display("test %s finished at %0t", nm, $time);
   endtask : drain

   // Monitor in mid-cycle, once registered outputs have settled
   always @(negedge clk_sys_i)
   begin
      if (cfg_rdy_o === 1'h1)
      begin
         exp_rd = (rd_q.size() != 0) ? rd_q.pop_front() : 17'h1FFFF;
         if (exp_rd[16])
            check(cfg_do_o, exp_rd[15:0]);
      end
      // A start racing a mode write is cancelled by the restart
      if (conv_go_o === 1'h1 && seq_reset_o === 1'h0 && ch_q.size() != 0)
         check(16'(chan_a_o), 16'(ch_q.pop_front()));
      else if (conv_go_o === 1'h1 && seq_reset_o === 1'h0 && strict)
         check(16'(conv_go_o), 16'h0000);
   end

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      wd = 16'($urandom(32'h35EDBF20));
      scan(DEFAULT_SCAN);
      repeat (16) @(posedge clk_sys_i);
      rstn_i <= 1'h1;
      drain(3000, "default");
      // Reset values, unmapped place, random write and read back
      foreach (offs[i])
         acc(1'h0, offs[i], RST_REG);
      acc(1'h1, 7'h42, wd);
      acc(1'h0, 7'h42, 16'h0000);
      val[0] = 16'($urandom()) & 16'h051F;
      for (int i = 2; i < 10; i++)
         val[i] = 16'($urandom());
      val[2] = val[2] & 16'h7FE1 | 16'h0001;
      foreach (offs[i])
         if (i != 1)
         begin
            acc(1'h1, offs[i], val[i]);
            acc(1'h0, offs[i], val[i]);
         end
      $display("test registers finished at %0t", $time);
      // One pass, then single channel with the programmed settings
      set_mode(MODE_ONE_PASS);
      scan({val[3], val[2]});
      repeat (2) ch_q.push_back(val[0][4:0]);
      drain(5000, "one pass");
      // First and last positions, two passes back to back
      acc(1'h1, OFS_SEL_ONCHIP, 16'h0001);
      acc(1'h1, OFS_SEL_AUX, 16'h8000);
      set_mode(MODE_CONTINUOUS);
      repeat (2) scan(32'h8000_0001);
      drain(1000, "continuous");
      acc(1'h1, OFS_CONFIG_ZERO, 16'h051F);
      set_mode(MODE_SINGLE);
      repeat (2) ch_q.push_back(5'h1F);
      drain(1000, "single");
      acc(1'h1, OFS_SEL_ONCHIP, 16'h0000);
      acc(1'h1, OFS_SEL_AUX, 16'hFF00);
      set_mode(MODE_SIMULT);
      scan(32'hFF00_0000);
      drain(2000, "simultaneous");
      acc(1'h1, OFS_SEL_ONCHIP, val[2]);
      acc(1'h1, OFS_SEL_AUX, val[3]);
      set_mode(MODE_INDEP);
      scan({val[3], val[2]});
      drain(5000, "independent");
      // Event driven: silent until the start pin rises, then exactly one
      event_mode_i <= 1'h1;
      set_mode(MODE_SINGLE);
      repeat (2) @(posedge clk_sys_i);
      strict = 1'h1;
      repeat (300) @(posedge clk_sys_i);
      ch_q.push_back(5'h1F);
      convst_i <= 1'h1;
      repeat (4) @(posedge clk_sys_i);
      convst_i <= 1'h0;
      drain(400, "event");
      repeat (300) @(posedge clk_sys_i);
      test_done();
   end
endmodule : tb
